// ===== core/nvc_pkg.sv
// package for the host-side controller of a parallel nonvolatile sram with timekeeper
// assumes one 100 MHz clock domain and a device on an asynchronous sram bus
//
// How it works
// - sequence opens with reads 4E38, B1C7, 83E0
// - then reads 7C1F and 703F
// - six reads consecutive, write enable high
// - store after changing autosave setting (controller only sets the save-due status bit, issues no store)
// - read-hold bit freezes user time registers
// - write bit stops updates, allows setting
// - store after transfer delay when autosave off (controller sets the save-due status bit, then waits the delay, issues no store)
package nvc_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    // host command register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CFG = 4'h5;
    // command codes written to REG_CMD
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h2;
    localparam logic [3:0] CMD_AUTO_OFF = 4'h3;
    localparam logic [3:0] CMD_AUTO_ON = 4'h4;
    localparam logic [3:0] CMD_STORE = 4'h5;
    localparam logic [3:0] CMD_RECALL = 4'h6;
    localparam logic [3:0] CMD_HOLD_ON = 4'h7;
    localparam logic [3:0] CMD_HOLD_OFF = 4'h8;
    localparam logic [3:0] CMD_SET_ON = 4'h9;
    localparam logic [3:0] CMD_SET_OFF = 4'hA;
    // sequence table, entries 0..4 common, then per command
    localparam logic [15:0] SEQ_A0 = 16'h4E38;
    localparam logic [15:0] SEQ_A1 = 16'hB1C7;
    localparam logic [15:0] SEQ_A2 = 16'h83E0;
    localparam logic [15:0] SEQ_A3 = 16'h7C1F;
    localparam logic [15:0] SEQ_A4 = 16'h703F;
    localparam logic [15:0] SEQ_AUTO_OFF = 16'h8B45;
    localparam logic [15:0] SEQ_AUTO_ON = 16'h4B46;
    localparam logic [15:0] SEQ_STORE = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL = 16'h4C63;
    localparam logic [2:0] SEQ_LAST = 3'h5;
    // timekeeper window
    localparam logic [ADDR_W-1:0] TK_FLAGS_X8 = 21'h1FFFF0;
    localparam logic [ADDR_W-1:0] TK_TOP_X8 = 21'h1FFFFF;
    localparam logic [ADDR_W-1:0] TK_FLAGS_X16 = 21'h0FFFF0;
    localparam logic [ADDR_W-1:0] TK_TOP_X16 = 21'h0FFFFF;
    localparam int FLAG_HOLD_BIT = 0;
    localparam int FLAG_SET_BIT = 1;
    // status bits
    localparam int ST_BUSY = 0;
    localparam int ST_BUSY_LINE = 1;
    localparam int ST_AUTO = 2;
    localparam int ST_SAVE_DUE = 3;
    localparam int ST_DONE = 4;
    // bus timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS = 45;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS = 20;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_RELEASE_NS = 5000;
    localparam int BUSY_RELEASE_CYC = (BUSY_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XFER_US = 350;
    localparam int XFER_DELAY_CYC = (XFER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    typedef struct packed {
        logic cs1_n;
        logic cs2;
        logic we_n;
        logic oe_n;
        logic ub_n;
        logic lb_n;
    } nvc_ctl_s;

    localparam nvc_ctl_s CTL_IDLE = '{cs1_n: 1'b1, cs2: 1'b0, we_n: 1'b1, oe_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_RECOV = 3'b011,
        ST_WAIT_BUSY = 3'b100,
        ST_SETTLE = 3'b101
    } nvc_state_e;
endpackage

// ===== core/nvc_bus_cycle.sv
// one asynchronous sram bus cycle: drives controls, address and data, captures read data
// assumes the busy line is already synchronised by the caller
`timescale 1ns/10ps
module nvc_bus_cycle (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic write_in,
    input wire logic [nvc_pkg::ADDR_W-1:0] addr_in,
    input wire logic [nvc_pkg::DATA_W-1:0] wdata_in,
    input wire logic [nvc_pkg::DATA_W-1:0] dq_in,
    input wire logic busy_in,
    output logic done_out,
    output logic [nvc_pkg::DATA_W-1:0] rdata_out,
    output nvc_pkg::nvc_ctl_s ctl_out,
    output logic [nvc_pkg::ADDR_W-1:0] addr_out,
    output logic [nvc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_out
);
    nvc_pkg::nvc_state_e state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic done_reg, done_next;
    logic [nvc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    nvc_pkg::nvc_ctl_s ctl_reg, ctl_next;
    logic [nvc_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [nvc_pkg::DATA_W-1:0] dq_reg, dq_next;
    logic oe_reg, oe_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        done_next = 1'b0;
        rdata_next = rdata_reg;
        ctl_next = ctl_reg;
        addr_next = addr_reg;
        dq_next = dq_reg;
        oe_next = oe_reg;
        unique case (state_reg)
            nvc_pkg::ST_IDLE: begin
                if (start_in) begin
                    wr_next = write_in;
                    addr_next = addr_in;
                    dq_next = wdata_in;
                    state_next = nvc_pkg::ST_SETUP;
                end
            end
            nvc_pkg::ST_SETUP: begin
                // one cycle of address setup before select
                ctl_next.cs1_n = 1'b0;
                ctl_next.cs2 = 1'b1;
                ctl_next.ub_n = 1'b0;
                ctl_next.lb_n = 1'b0;
                ctl_next.we_n = ~wr_reg;
                ctl_next.oe_n = wr_reg;
                oe_next = wr_reg;
                cnt_next = 8'(nvc_pkg::ACCESS_CYC);
                state_next = nvc_pkg::ST_ACTIVE;
            end
            nvc_pkg::ST_ACTIVE: begin
                if (cnt_reg > 8'h01) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    rdata_next = dq_in;
                    ctl_next = nvc_pkg::CTL_IDLE;
                    cnt_next = 8'(nvc_pkg::RECOVER_CYC);
                    state_next = nvc_pkg::ST_RECOV;
                end
            end
            nvc_pkg::ST_RECOV: begin
                oe_next = 1'b0;
                if (cnt_reg > 8'h01) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    done_next = 1'b1;
                    state_next = nvc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = nvc_pkg::ST_IDLE;
            end
        endcase
        if (busy_in && state_reg == nvc_pkg::ST_IDLE) begin
            state_next = nvc_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_reg <= nvc_pkg::ST_IDLE;
            cnt_reg <= 8'h00;
            wr_reg <= 1'b0;
            done_reg <= 1'b0;
            rdata_reg <= 8'h00;
            ctl_reg <= nvc_pkg::CTL_IDLE;
            addr_reg <= 21'h000000;
            dq_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            done_reg <= done_next;
            rdata_reg <= rdata_next;
            ctl_reg <= ctl_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            oe_reg <= oe_next;
        end
    end

    assign done_out = done_reg;
    assign rdata_out = rdata_reg;
    assign ctl_out = ctl_reg;
    assign addr_out = addr_reg;
    assign dq_out = dq_reg;
    assign dq_oe_out = oe_reg;
endmodule

// ===== core/nvc_host.sv
// host controller: runs software mode sequences, timekeeper flag control and plain accesses
// assumes the device bus pins are joined by the bench; busy line arrives asynchronously
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module nvc_host (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic [nvc_pkg::DATA_W-1:0] dq_in,
    input wire logic store_busy_line_n_in,
    output logic [nvc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic [nvc_pkg::ADDR_W-1:0] addr_out,
    output logic chip_select_primary_n_out,
    output logic chip_select_secondary_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic upper_byte_sel_n_out,
    output logic lower_byte_sel_n_out
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_ISSUE = 3'b001,
        HS_WAIT = 3'b010,
        HS_BUSY = 3'b011,
        HS_SETTLE = 3'b100
    } nvc_hstate_e;

    nvc_hstate_e hs_reg, hs_next;
    logic [3:0] cmd_reg, cmd_next;
    logic [2:0] step_reg, step_next;
    logic [nvc_pkg::ADDR_W-1:0] addr_reg, addr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] rdata_reg, rdata_next;
    logic auto_reg, auto_next;
    logic save_due_reg, save_due_next;
    logic done_reg, done_next;
    logic wide_reg, wide_next;
    logic [7:0] flags_reg, flags_next;
    logic [nvc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [31:0] rd_reg, rd_next;
    logic busy_s1_reg, busy_s2_reg;
    logic cyc_start, cyc_write, cyc_done;
    logic [nvc_pkg::ADDR_W-1:0] cyc_addr;
    logic [7:0] cyc_wdata, cyc_rdata;
    logic [15:0] seq_word;
    logic [nvc_pkg::ADDR_W-1:0] flags_addr;
    logic busy_low;
    nvc_pkg::nvc_ctl_s ctl;

    // busy line is asynchronous to clk_in
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            busy_s1_reg <= 1'b1;
            busy_s2_reg <= 1'b1;
        end else begin
            busy_s1_reg <= store_busy_line_n_in;
            busy_s2_reg <= busy_s1_reg;
        end
    end
    assign busy_low = ~busy_s2_reg;

    assign flags_addr = wide_reg ? nvc_pkg::TK_FLAGS_X16 : nvc_pkg::TK_FLAGS_X8;

    always_comb begin
        seq_word = nvc_pkg::SEQ_A0;
        unique case (step_reg)
            3'h0: seq_word = nvc_pkg::SEQ_A0;
            3'h1: seq_word = nvc_pkg::SEQ_A1;
            3'h2: seq_word = nvc_pkg::SEQ_A2;
            3'h3: seq_word = nvc_pkg::SEQ_A3;
            3'h4: seq_word = nvc_pkg::SEQ_A4;
            default: begin
                unique case (cmd_reg)
                    nvc_pkg::CMD_AUTO_OFF: seq_word = nvc_pkg::SEQ_AUTO_OFF;
                    nvc_pkg::CMD_AUTO_ON: seq_word = nvc_pkg::SEQ_AUTO_ON;
                    nvc_pkg::CMD_STORE: seq_word = nvc_pkg::SEQ_STORE;
                    default: seq_word = nvc_pkg::SEQ_RECALL;
                endcase
            end
        endcase
    end

    function automatic logic is_seq(input logic [3:0] c);
        is_seq = (c == nvc_pkg::CMD_AUTO_OFF) || (c == nvc_pkg::CMD_AUTO_ON) ||
                 (c == nvc_pkg::CMD_STORE) || (c == nvc_pkg::CMD_RECALL);
    endfunction

    function automatic logic is_flag(input logic [3:0] c);
        is_flag = (c >= nvc_pkg::CMD_HOLD_ON) && (c <= nvc_pkg::CMD_SET_OFF);
    endfunction

    always_comb begin
        hs_next = hs_reg;
        cmd_next = cmd_reg;
        step_next = step_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        auto_next = auto_reg;
        save_due_next = save_due_reg;
        done_next = done_reg;
        wide_next = wide_reg;
        flags_next = flags_reg;
        cnt_next = cnt_reg;
        rd_next = 32'h00000000;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        cyc_addr = addr_reg;
        cyc_wdata = wdata_reg;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                nvc_pkg::REG_ADDR: rd_next = {11'h000, addr_reg};
                nvc_pkg::REG_WDATA: rd_next = {24'h000000, wdata_reg};
                nvc_pkg::REG_RDATA: rd_next = {24'h000000, rdata_reg};
                nvc_pkg::REG_STATUS: rd_next = {27'h0000000, done_reg, save_due_reg, auto_reg, busy_s2_reg,
                                                (hs_reg != HS_IDLE)};
                nvc_pkg::REG_CFG: rd_next = {23'h000000, wide_reg, flags_reg};
                default: rd_next = 32'h00000000;
            endcase
        end
        if (reg_wr_in && hs_reg == HS_IDLE) begin
            unique case (reg_addr_in)
                nvc_pkg::REG_ADDR: addr_next = reg_wdata_in[nvc_pkg::ADDR_W-1:0];
                nvc_pkg::REG_WDATA: wdata_next = reg_wdata_in[7:0];
                nvc_pkg::REG_CFG: wide_next = reg_wdata_in[8];
                nvc_pkg::REG_CMD: begin
                    if (reg_wdata_in[3:0] != 4'h0) begin
                        cmd_next = reg_wdata_in[3:0];
                        step_next = 3'h0;
                        done_next = 1'b0;
                        hs_next = HS_ISSUE;
                    end
                end
                default: begin
                end
            endcase
        end
        unique case (hs_reg)
            HS_IDLE: begin
            end
            HS_ISSUE: begin
                // no store or write while the device holds the busy line low
                if (!busy_low) begin
                    cyc_start = 1'b1;
                    if (is_seq(cmd_reg)) begin
                        // only bits 14..2 matter; others kept at zero
                        cyc_addr = {6'h00, seq_word[14:2], 2'h0};
                    end else if (is_flag(cmd_reg)) begin
                        cyc_write = 1'b1;
                        cyc_addr = flags_addr;
                        cyc_wdata = flags_reg;
                        unique case (cmd_reg)
                            nvc_pkg::CMD_HOLD_ON: cyc_wdata[nvc_pkg::FLAG_HOLD_BIT] = 1'b1;
                            nvc_pkg::CMD_HOLD_OFF: cyc_wdata[nvc_pkg::FLAG_HOLD_BIT] = 1'b0;
                            nvc_pkg::CMD_SET_ON: cyc_wdata[nvc_pkg::FLAG_SET_BIT] = 1'b1;
                            default: cyc_wdata[nvc_pkg::FLAG_SET_BIT] = 1'b0;
                        endcase
                        flags_next = cyc_wdata;
                    end else begin
                        cyc_write = (cmd_reg == nvc_pkg::CMD_WRITE);
                    end
                    hs_next = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (cyc_done) begin
                    if (is_seq(cmd_reg) && step_reg != nvc_pkg::SEQ_LAST) begin
                        // back to back reads, nothing may intervene
                        step_next = step_reg + 3'h1;
                        hs_next = HS_ISSUE;
                    end else begin
                        rdata_next = cyc_rdata;
                        unique case (cmd_reg)
                            nvc_pkg::CMD_AUTO_OFF: begin
                                auto_next = 1'b0;
                                save_due_next = 1'b1;
                            end
                            nvc_pkg::CMD_AUTO_ON: begin
                                auto_next = 1'b1;
                                save_due_next = 1'b1;
                            end
                            nvc_pkg::CMD_STORE: save_due_next = 1'b0;
                            nvc_pkg::CMD_SET_OFF: save_due_next = ~auto_reg;
                            default: begin
                            end
                        endcase
                        if (cmd_reg == nvc_pkg::CMD_STORE || cmd_reg == nvc_pkg::CMD_RECALL) begin
                            cnt_next = nvc_pkg::CNT_W'(nvc_pkg::BUSY_RELEASE_CYC);
                            hs_next = HS_BUSY;
                        end else if (cmd_reg == nvc_pkg::CMD_SET_OFF) begin
                            // give the timekeeper time to load its counters
                            cnt_next = nvc_pkg::CNT_W'(nvc_pkg::XFER_DELAY_CYC);
                            hs_next = HS_SETTLE;
                        end else begin
                            done_next = 1'b1;
                            hs_next = HS_IDLE;
                        end
                    end
                end
            end
            HS_BUSY: begin
                // wait out busy, then the output-active delay after release
                if (busy_low) begin
                    cnt_next = nvc_pkg::CNT_W'(nvc_pkg::BUSY_RELEASE_CYC);
                end else begin
                    hs_next = HS_SETTLE;
                end
            end
            HS_SETTLE: begin
                if (cnt_reg > nvc_pkg::CNT_W'(1)) begin
                    cnt_next = cnt_reg - nvc_pkg::CNT_W'(1);
                end else begin
                    done_next = 1'b1;
                    hs_next = HS_IDLE;
                end
            end
            default: begin
                hs_next = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hs_reg <= HS_IDLE;
            cmd_reg <= 4'h0;
            step_reg <= 3'h0;
            addr_reg <= 21'h000000;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            auto_reg <= 1'b1;
            save_due_reg <= 1'b0;
            done_reg <= 1'b0;
            wide_reg <= 1'b0;
            flags_reg <= 8'h00;
            cnt_reg <= '0;
            rd_reg <= 32'h00000000;
        end else begin
            hs_reg <= hs_next;
            cmd_reg <= cmd_next;
            step_reg <= step_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            auto_reg <= auto_next;
            save_due_reg <= save_due_next;
            done_reg <= done_next;
            wide_reg <= wide_next;
            flags_reg <= flags_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
        end
    end

    nvc_bus_cycle u_cycle (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .start_in(cyc_start),
        .write_in(cyc_write),
        .addr_in(cyc_addr),
        .wdata_in(cyc_wdata),
        .dq_in(dq_in),
        .busy_in(busy_low),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata),
        .ctl_out(ctl),
        .addr_out(addr_out),
        .dq_out(dq_out),
        .dq_oe_out(dq_oe_out)
    );

    assign reg_rdata_out = rd_reg;
    assign chip_select_primary_n_out = ctl.cs1_n;
    assign chip_select_secondary_out = ctl.cs2;
    assign we_n_out = ctl.we_n;
    assign oe_n_out = ctl.oe_n;
    assign upper_byte_sel_n_out = ctl.ub_n;
    assign lower_byte_sel_n_out = ctl.lb_n;
endmodule

// ===== bench/nvc_host_asserts.sv
// checker on the bus pins of the host controller
// assumes it is bound into nvc_host and sees its ports only
`timescale 1ns/10ps
module nvc_chk (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic store_busy_line_n_in,
    input wire logic [nvc_pkg::ADDR_W-1:0] addr_out,
    input wire logic chip_select_primary_n_out,
    input wire logic chip_select_secondary_out,
    input wire logic we_n_out,
    input wire logic oe_n_out,
    input wire logic upper_byte_sel_n_out,
    input wire logic lower_byte_sel_n_out
);
    logic [14:2] last_reg;
    int gap_reg;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // start address of the previous read, for order checks
    always_ff @(posedge clk_in) begin
        if ($fell(oe_n_out)) begin
            last_reg <= addr_out[14:2];
        end
        if (reset_in) begin
            gap_reg <= 1000;
        end else if ($rose(store_busy_line_n_in)) begin
            gap_reg <= 0;
        end else if (gap_reg < 1000) begin
            gap_reg <= gap_reg + 1;
        end
    end
    cs_pair_a: assert property (!(oe_n_out && we_n_out) |->
        !chip_select_primary_n_out && chip_select_secondary_out) else $error("select pins wrong in access");
    read_we_a: assert property (!oe_n_out |-> we_n_out) else $error("write enable low in read");
    read_hold_a: assert property ($fell(oe_n_out) |-> !oe_n_out [*5] ##1 oe_n_out)
        else $error("read strobe length wrong");
    recover_a: assert property ($rose(oe_n_out) |-> chip_select_primary_n_out [*2])
        else $error("no recovery after read");
    byte_sel_a: assert property (!chip_select_primary_n_out |->
        !upper_byte_sel_n_out && !lower_byte_sel_n_out) else $error("byte selects not low");
    busy_block_a: assert property (!store_busy_line_n_in [*8] |->
        !$fell(chip_select_primary_n_out)) else $error("access started while busy");
    release_gap_a: assert property (gap_reg < 490 |-> chip_select_primary_n_out)
        else $error("access too soon after busy release");
    order_first_a: assert property ($fell(oe_n_out) && addr_out[14:2] == nvc_pkg::SEQ_A1[14:2] |->
        last_reg == nvc_pkg::SEQ_A0[14:2]) else $error("prefix order broken");
    order_mid_a: assert property ($fell(oe_n_out) && addr_out[14:2] == nvc_pkg::SEQ_A4[14:2] |->
        last_reg == nvc_pkg::SEQ_A3[14:2]) else $error("fifth read out of order");
endmodule
bind nvc_host nvc_chk chk (.*);

// ===== bench/nvc_dev_model.sv
// behavioural model of the memory device on the far side of the bus
// assumes the host clock as a sampling reference; the part itself has none
`timescale 1ns/10ps
module nvc_dev (
    input wire logic clk_in,
    input wire logic [20:0] addr_in,
    input wire logic [7:0] dq_in,
    input wire logic dq_oe_in,
    input wire logic chip_select_primary_n_in,
    input wire logic chip_select_secondary_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    output logic [7:0] dq_out,
    output logic store_busy_line_n_out
);
    localparam logic [15:0] SEQ [9] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F,
        16'h8B45, 16'h4B46, 16'h8FC0, 16'h4C63};
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [7:0] flags = 8'h00;
    logic [2:0] step = 3'h0;
    logic auto_en = 1'b1;
    logic hz = 1'b0;
    logic rd_d = 1'b0;
    int n_store = 0;
    int n_recall = 0;
    int busy_cnt = 0;
    wire logic sel = !chip_select_primary_n_in && chip_select_secondary_in;
    wire logic rd_now = sel && !oe_n_in && we_n_in;
    wire logic [12:0] a = addr_in[14:2];
    // a released bus flips every cycle so a stale value never looks valid
    assign dq_out = (rd_now && !hz) ? mem[addr_in[7:0]] : ~last;
    assign store_busy_line_n_out = (busy_cnt == 0);
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge clk_in) begin
        rd_d <= rd_now;
        last <= dq_out;
        if (!rd_now) hz <= 1'b0;
        if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        if (sel && !we_n_in && dq_oe_in) begin
            step <= 3'h0;
            if (addr_in == 21'h1FFFF0) flags <= dq_in;
            else mem[addr_in[7:0]] <= dq_in;
        end
        if (rd_now && !rd_d) begin
            if (step == 3'h5) begin
                step <= 3'h0;
                if (a == SEQ[5][14:2]) auto_en <= 1'b0;
                if (a == SEQ[6][14:2]) auto_en <= 1'b1;
                if (a == SEQ[7][14:2] || a == SEQ[8][14:2]) begin
                    hz <= 1'b1;
                    busy_cnt <= 20;
                    n_store <= n_store + (a == SEQ[7][14:2]);
                    n_recall <= n_recall + (a == SEQ[8][14:2]);
                end
            end else if (a == SEQ[step][14:2]) step <= step + 3'h1;
            else step <= {2'b00, a == SEQ[0][14:2]};
        end
    end
endmodule

// ===== bench/testbench.sv
// self-checking bench: host controller driving the device model
// assumes one 100 MHz clock and the register map of the package
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [3:0] c;
        logic au;
        logic sd;
        logic [1:0] fl;
        logic [1:0] st;
        logic [1:0] rc;
    } nvc_row_s;
    nvc_row_s rows [8] = '{'{nvc_pkg::CMD_AUTO_OFF, 1'b0, 1'b1, 2'h0, 2'h0, 2'h0},
        '{nvc_pkg::CMD_AUTO_ON, 1'b1, 1'b1, 2'h0, 2'h0, 2'h0}, '{nvc_pkg::CMD_STORE, 1'b1, 1'b0, 2'h0, 2'h1, 2'h0},
        '{nvc_pkg::CMD_RECALL, 1'b1, 1'b0, 2'h0, 2'h1, 2'h1}, '{nvc_pkg::CMD_HOLD_ON, 1'b1, 1'b0, 2'h1, 2'h1, 2'h1},
        '{nvc_pkg::CMD_HOLD_OFF, 1'b1, 1'b0, 2'h0, 2'h1, 2'h1}, '{nvc_pkg::CMD_SET_ON, 1'b1, 1'b0, 2'h2, 2'h1, 2'h1},
        '{nvc_pkg::CMD_SET_OFF, 1'b1, 1'b0, 2'h0, 2'h1, 2'h1}};
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] ra = 4'h0;
    logic [31:0] wd = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    wire logic [7:0] dq_h;
    wire logic [7:0] dq_d;
    wire logic [20:0] addr;
    wire logic dq_oe, cs_p_n, cs_s, we_n, oe_n, busy_n;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rdata_s;
    always #5 clk_in = ~clk_in;
    nvc_host dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdata), .dq_in(dq_d), .store_busy_line_n_in(busy_n), .dq_out(dq_h),
        .dq_oe_out(dq_oe), .addr_out(addr), .chip_select_primary_n_out(cs_p_n), .chip_select_secondary_out(cs_s),
        .we_n_out(we_n), .oe_n_out(oe_n), .upper_byte_sel_n_out(), .lower_byte_sel_n_out());
    nvc_dev m (.clk_in(clk_in), .addr_in(addr), .dq_in(dq_h), .dq_oe_in(dq_oe), .chip_select_primary_n_in(cs_p_n),
        .chip_select_secondary_in(cs_s), .we_n_in(we_n), .oe_n_in(oe_n), .dq_out(dq_d), .store_busy_line_n_out(busy_n));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        ra <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        ra <= a;
        rd_s <= 1'b1;
        @(posedge clk_in);
        rd_s <= 1'b0;
        @(posedge clk_in);
        d = rdata;
    endtask
    task automatic run(input logic [3:0] c);
        logic [31:0] s;
        wr(nvc_pkg::REG_CMD, {28'h0, c});
        for (int i = 0; i < 20000; i++) begin
            rd(nvc_pkg::REG_STATUS, s);
            if (s[nvc_pkg::ST_DONE] === 1'b1) break;
        end
        check("command done", 32'h1, s[nvc_pkg::ST_DONE]);
        rdata_s = s;
    endtask
    logic [31:0] got;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 95000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        foreach (rows[i]) begin
            run(rows[i].c);
            check("device autosave", rows[i].au, m.auto_en);
            check("status autosave", rows[i].au, rdata_s[nvc_pkg::ST_AUTO]);
            check("status save due", rows[i].sd, rdata_s[nvc_pkg::ST_SAVE_DUE]);
            check("flags hold and set", rows[i].fl, m.flags[1:0]);
            check("store count", rows[i].st, m.n_store);
            check("recall count", rows[i].rc, m.n_recall);
        end
        wr(nvc_pkg::REG_ADDR, 32'h6);
        run(nvc_pkg::CMD_READ);
        rd(nvc_pkg::REG_RDATA, got);
        check("fresh cell", 32'h0, got);
        wr(nvc_pkg::REG_WDATA, 32'hA5);
        run(nvc_pkg::CMD_WRITE);
        check("device cell", 32'hA5, m.mem[6]);
        run(nvc_pkg::CMD_READ);
        rd(nvc_pkg::REG_RDATA, got);
        check("read back", 32'hA5, got);
        wr(nvc_pkg::REG_CFG, 32'h100);
        run(nvc_pkg::CMD_HOLD_ON);
        check("word flags cell", 32'h1, m.mem[8'hF0]);
        rd(nvc_pkg::REG_CFG, got);
        check("cfg readback", 32'h101, got);
        run(nvc_pkg::CMD_AUTO_OFF);
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        wr(4'hE, 32'hFFFF);
        rd(nvc_pkg::REG_STATUS, got);
        check("status after reset", 32'h4, got & 32'h1D);
        tally_and_finish();
    end
endmodule
